/* fast_lockup_regs.svh */
`ifndef FAST_LOCKUP_REGS_SVH
`define FAST_LOCKUP_REGS_SVH

// How it works
// [RULE_01] enable bit D16 arms boost current and period; zero leaves them unused
// [RULE_02] boost code D15:D13 gives boost pump current of unit times code plus four
// [RULE_03] host writes boost period count D12:D0 between 1 and 8191, never zero
// [RULE_04] boost pump stays on for count phase-detector periods, then normal pump returns
// [RULE_05] second loop-filter resistor switch is closed exactly while boost is on
// [RULE_06] host writes every address after power-down release before trusting settings
// [RULE_07] numerator takes effect only on integer write; host writes numerator first
// [RULE_08] outside boost, normal pump current is unit times 4-bit code plus one
// [RULE_09] each integer write with boost enabled restarts the count, one down per phase-detector period; the code skips the restart while the count is zero

// serial frame: 20 data bits then 4 address bits, first bit shifted in is D19
`define FRAME_BITS        24
`define ADDR_WIDTH        4
`define DATA_WIDTH        20
`define ADDR_NUM          4'h1
`define ADDR_INT          4'h2
`define ADDR_FAST         4'h4
`define NUM_MSB           17
`define INT_MSB           14
`define NORMAL_CODE_MSB   18
`define NORMAL_CODE_LSB   15
`define BOOST_EN_BIT      16
`define BOOST_CODE_MSB    15
`define BOOST_CODE_LSB    13
`define FAST_MSB          12
`define BOOST_CODE_OFFSET 5'h04
`define NORMAL_CODE_OFFSET 5'h01
`define SYNC_STAGES       3

`endif

/* fast_lockup_pkg.sv */
package fast_lockup_pkg;
    typedef enum logic [0:0] {
        PUMP_NORMAL = 1'b0,
        PUMP_BOOST  = 1'b1
    } pump_state_t;
endpackage

/* pin_filter.sv */
`timescale 1ns/1ps
`include "fast_lockup_regs.svh"

// three-stage synchroniser; output moves only when stages two and three agree
module pin_filter (
    input  wire logic ref_clk,  // system clock
    input  wire logic reset,    // async, active high
    input  wire logic pinIn,    // asynchronous pin
    output logic      pinOut_q  // filtered level
);
    logic [`SYNC_STAGES-1:0] stage_q;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            stage_q <= '0;
        end else begin
            stage_q <= {stage_q[`SYNC_STAGES-2:0], pinIn};
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pinOut_q <= 1'b0;
        end else if (stage_q[1] == stage_q[2]) begin
            pinOut_q <= stage_q[2];
        end
    end
endmodule // pin_filter

/* fast_lockup_control.sv */
`timescale 1ns/1ps
`include "fast_lockup_regs.svh"

module fast_lockup_control (
    input  wire logic        ref_clk,            // 200 MHz system clock
    input  wire logic        reset,              // async, active high
    input  wire logic        serialClk,          // three-wire interface clock pin
    input  wire logic        serialData,         // three-wire interface data pin
    input  wire logic        loadEnable,         // three-wire interface latch pin
    input  wire logic        power_down_release, // high: device powered
    input  wire logic        pdClk,              // phase-detector (divided reference) clock
    output logic [17:0]      numerator_q,        // committed numerator
    output logic [14:0]      integer_q,          // committed integer
    output logic [3:0]       normal_pump_current_code_q, // normal pump code
    output logic [2:0]       boost_pump_current_code_q,  // boost pump code
    output logic             boost_enable_q,     // fast lockup armed
    output logic             boostActive_q,      // boost pump on
    output logic             filterSwitch_q,     // parallel resistor switch closed
    output logic [4:0]       pumpUnits_q         // pump current in base units
);
    logic [4:0] filt;
    logic [4:0] filtPrev_q;
    logic [4:0] pinVec;

    assign pinVec = {pdClk, power_down_release, loadEnable, serialData, serialClk};

    // each pin settles 3 to 4 cycles late, and the host must hold every level at least 2 cycles for it to pass
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : gen_pin
            pin_filter u_filter (
                .ref_clk  (ref_clk),
                .reset    (reset),
                .pinIn    (pinVec[g]),
                .pinOut_q (filt[g])
            );
        end
    endgenerate

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            filtPrev_q <= '0;
        end else begin
            filtPrev_q <= filt;
        end
    end

    // the latch idles high, so one false rise follows reset; shift_q is clear then and address 0 is ignored
    logic sclkRise;
    logic leRise;
    logic pdRise;
    logic powered;
    assign sclkRise = filt[0] & ~filtPrev_q[0] & ~filt[2];
    assign leRise   = filt[2] & ~filtPrev_q[2];
    assign pdRise   = filt[4] & ~filtPrev_q[4];
    assign powered  = filt[3];

    // serial shifter
    logic [`FRAME_BITS-1:0] shift_q;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            shift_q <= '0;
        end else if (sclkRise) begin
            shift_q <= {shift_q[`FRAME_BITS-2:0], filt[1]};
        end
    end

    logic [`ADDR_WIDTH-1:0] frameAddr;
    logic [`DATA_WIDTH-1:0] frameData;
    logic                   wrNum;
    logic                   wrInt;
    logic                   wrFast;
    assign frameAddr = shift_q[`ADDR_WIDTH-1:0];
    assign frameData = shift_q[`FRAME_BITS-1:`ADDR_WIDTH];
    assign wrNum  = leRise & powered & (frameAddr == `ADDR_NUM);
    assign wrInt  = leRise & powered & (frameAddr == `ADDR_INT);
    assign wrFast = leRise & powered & (frameAddr == `ADDR_FAST);

    // numerator is staged and only reaches the synthesizer on an integer write
    logic [17:0] numStage_q;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            numStage_q <= '0;
        end else if (wrNum) begin
            numStage_q <= frameData[`NUM_MSB:0];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            numerator_q                <= '0;
            integer_q                  <= '0;
            normal_pump_current_code_q <= '0;
        end else if (wrInt) begin
            numerator_q                <= numStage_q; // RULE_07
            integer_q                  <= frameData[`INT_MSB:0];
            // the normal pump code rides on the integer word, so it also waits for the commit
            normal_pump_current_code_q <= frameData[`NORMAL_CODE_MSB:`NORMAL_CODE_LSB];
        end
    end

    // a write with the enable clear also ends a running boost in the state machine below
    logic [12:0] fastCount_q;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            boost_enable_q            <= 1'b0;
            boost_pump_current_code_q <= '0;
            fastCount_q               <= '0;
        end else if (wrFast) begin
            boost_enable_q            <= frameData[`BOOST_EN_BIT]; // RULE_01
            boost_pump_current_code_q <= frameData[`BOOST_CODE_MSB:`BOOST_CODE_LSB];
            fastCount_q               <= frameData[`FAST_MSB:0];
        end
    end

    // boost interval: start on commit, count phase-detector edges down to zero
    fast_lockup_pkg::pump_state_t state_q;
    fast_lockup_pkg::pump_state_t state_d;
    logic [12:0] remain_q;
    logic [12:0] remain_d;

    always_comb begin
        state_d  = state_q;
        remain_d = remain_q;
        case (state_q)
            fast_lockup_pkg::PUMP_NORMAL: begin
                if (wrInt && boost_enable_q && fastCount_q != 13'h0000) begin
                    state_d  = fast_lockup_pkg::PUMP_BOOST; // RULE_09
                    remain_d = fastCount_q;
                end
            end
            fast_lockup_pkg::PUMP_BOOST: begin
                // power-down or a disabling write end the boost at once, whatever is left
                if (!powered || !boost_enable_q) begin
                    state_d = fast_lockup_pkg::PUMP_NORMAL; // RULE_01
                end else if (wrInt && fastCount_q != 13'h0000) begin
                    remain_d = fastCount_q; // RULE_09
                end else if (pdRise) begin
                    // a zero count would wrap and run 8192 periods, so it is refused at start
                    remain_d = remain_q - 13'h0001;
                    if (remain_q == 13'h0001) begin
                        state_d = fast_lockup_pkg::PUMP_NORMAL; // RULE_04
                    end
                end
            end
            default: begin
                state_d = fast_lockup_pkg::PUMP_NORMAL;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_q        <= fast_lockup_pkg::PUMP_NORMAL;
            remain_q       <= '0;
            boostActive_q  <= 1'b0;
            filterSwitch_q <= 1'b0;
        end else begin
            state_q        <= state_d;
            remain_q       <= remain_d;
            boostActive_q  <= (state_d == fast_lockup_pkg::PUMP_BOOST); // RULE_04
            filterSwitch_q <= (state_d == fast_lockup_pkg::PUMP_BOOST); // RULE_05
        end
    end

    // current follows the pump state one cycle later; analog settling dwarfs 5 ns
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pumpUnits_q <= `NORMAL_CODE_OFFSET;
        end else if (boostActive_q) begin
            pumpUnits_q <= {2'b00, boost_pump_current_code_q} + `BOOST_CODE_OFFSET; // RULE_02
        end else begin
            pumpUnits_q <= {1'b0, normal_pump_current_code_q} + `NORMAL_CODE_OFFSET; // RULE_08
        end
    end

    chk_switch_tracks_boost: assert property (@(posedge ref_clk) disable iff (reset) // RULE_05
        filterSwitch_q == boostActive_q) else $error("filter switch differs from boost state");
    chk_boost_start_commit: assert property (@(posedge ref_clk) disable iff (reset) // RULE_09
        (wrInt && boost_enable_q && fastCount_q != 13'h0000 && powered) |=> boostActive_q && remain_q == $past(fastCount_q))
        else $error("boost did not start on integer commit");
    chk_disabled_no_boost: assert property (@(posedge ref_clk) disable iff (reset) // RULE_01
        !boost_enable_q |=> !boostActive_q) else $error("boost active while disabled");
    chk_boost_expires: assert property (@(posedge ref_clk) disable iff (reset) // RULE_04
        (state_q == fast_lockup_pkg::PUMP_BOOST && pdRise && remain_q == 13'h0001 && !wrInt) |=> !boostActive_q)
        else $error("boost outlived its count");
    chk_boost_counts_down: assert property (@(posedge ref_clk) disable iff (reset) // RULE_04
        (state_q == fast_lockup_pkg::PUMP_BOOST && pdRise && remain_q > 13'h0001 && !wrInt && boost_enable_q && powered)
        |=> remain_q == $past(remain_q) - 13'h0001 && boostActive_q) else $error("boost count step wrong");
    chk_boost_holds: assert property (@(posedge ref_clk) disable iff (reset) // RULE_04
        (boostActive_q && !pdRise && boost_enable_q && powered) |=> boostActive_q) else $error("boost ended without pd edge");
    chk_boost_current: assert property (@(posedge ref_clk) disable iff (reset) // RULE_02
        boostActive_q ##1 $stable(boost_pump_current_code_q) |-> pumpUnits_q == {2'b00, boost_pump_current_code_q} + 5'h04)
        else $error("boost current wrong");
    chk_normal_current: assert property (@(posedge ref_clk) disable iff (reset) // RULE_08
        !boostActive_q ##1 $stable(normal_pump_current_code_q) |-> pumpUnits_q == {1'b0, normal_pump_current_code_q} + 5'h01)
        else $error("normal current wrong");
    chk_numerator_staged: assert property (@(posedge ref_clk) disable iff (reset) // RULE_07
        !wrInt |=> $stable(numerator_q)) else $error("numerator changed without integer write");

    // write path, pump current and boost count checks
    chk_fast_write_lands: assert property (@(posedge ref_clk) disable iff (reset) // RULE_01
        wrFast |=> boost_enable_q == $past(frameData[`BOOST_EN_BIT]) && fastCount_q == $past(frameData[`FAST_MSB:0]))
        else $error("fast lockup write did not land");
    chk_boost_code_lands: assert property (@(posedge ref_clk) disable iff (reset) // RULE_02
        wrFast |=> boost_pump_current_code_q == $past(frameData[`BOOST_CODE_MSB:`BOOST_CODE_LSB]))
        else $error("boost code write did not land");
    chk_int_write_lands: assert property (@(posedge ref_clk) disable iff (reset) // RULE_07
        wrInt |=> numerator_q == $past(numStage_q) && integer_q == $past(frameData[`INT_MSB:0]))
        else $error("integer write did not commit the staged numerator");
    chk_normal_code_lands: assert property (@(posedge ref_clk) disable iff (reset) // RULE_08
        wrInt |=> normal_pump_current_code_q == $past(frameData[`NORMAL_CODE_MSB:`NORMAL_CODE_LSB]))
        else $error("normal code write did not land");
    chk_units_after_boost: assert property (@(posedge ref_clk) disable iff (reset) // RULE_08
        $fell(boostActive_q) |=> pumpUnits_q == {1'b0, $past(normal_pump_current_code_q)} + 5'h01)
        else $error("normal current not restored after boost");
    chk_remain_live: assert property (@(posedge ref_clk) disable iff (reset) // RULE_04
        boostActive_q |-> remain_q != 13'h0000)
        else $error("boost running with an empty count");

    cov_boost_start: cover property (@(posedge ref_clk) disable iff (reset) !boostActive_q ##1 boostActive_q);
    cov_boost_end: cover property (@(posedge ref_clk) disable iff (reset) boostActive_q ##1 !boostActive_q);
    cov_restart: cover property (@(posedge ref_clk) disable iff (reset) boostActive_q && wrInt);
    cov_fast_write: cover property (@(posedge ref_clk) disable iff (reset) wrFast);
    cov_write_refused: cover property (@(posedge ref_clk) disable iff (reset) leRise && !powered);
endmodule // fast_lockup_control

/* serial_host.sv */
`timescale 1ns/1ps

// host side of the three-wire bus; every pin level is held at least five ref_clk cycles
module serial_host (
    input  wire logic        ref_clk,    // system clock
    input  wire logic        reset,      // async, active high
    input  wire logic        start,      // one-cycle frame request
    input  wire logic [23:0] frame,      // data then address, msb sent first
    output logic             serialClk,  // serial clock, still outside frames
    output logic             serialData, // serial data
    output logic             loadEnable, // latch, rises to commit
    output logic             busy        // frame in progress
);
    logic [23:0] shift_q;
    logic [5:0]  phase_q;
    logic [2:0]  hold_q;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            busy       <= 1'b0;
            serialClk  <= 1'b0;
            serialData <= 1'b0;
            loadEnable <= 1'b1;
            phase_q    <= 6'h00;
            hold_q     <= 3'h0;
            shift_q    <= 24'h000000;
        end else if (start && !busy) begin
            busy       <= 1'b1;
            loadEnable <= 1'b0;
            shift_q    <= frame;
            phase_q    <= 6'h00;
            hold_q     <= 3'h0;
            serialData <= frame[23];
        end else if (busy) begin
            hold_q <= hold_q + 3'h1;
            if (hold_q == 3'h4) begin
                hold_q  <= 3'h0;
                phase_q <= phase_q + 6'h01;
                if (phase_q == 6'h30) begin
                    busy <= 1'b0;
                end else if (!phase_q[0]) begin
                    serialClk <= 1'b1;
                end else begin
                    serialClk <= 1'b0;
                    shift_q   <= shift_q << 1;
                    if (phase_q == 6'h2F) begin
                        loadEnable <= 1'b1;
                        // released data line must not keep showing the last bit
                        serialData <= ~serialData;
                    end else begin
                        serialData <= shift_q[22];
                    end
                end
            end
        end
    end
endmodule // serial_host

/* fast_lockup_control_bench.sv */
`timescale 1ns/1ps
`include "fast_lockup_regs.svh"

module fast_lockup_control_bench;
    logic        ref_clk, reset, start, busy, serialClk, serialData, loadEnable, power_down_release, pdClk, pdRun;
    logic [23:0] frame;
    logic [17:0] numerator_q, num, prevNum;
    logic [14:0] integer_q, intv;
    logic [3:0]  normal_pump_current_code_q, normCode;
    logic [2:0]  boost_pump_current_code_q, boostCode;
    logic        boost_enable_q, boostActive_q, filterSwitch_q;
    logic [4:0]  pumpUnits_q, unitsPrev;
    logic [5:0]  expQ[$];
    integer      n_mismatch, samples_checked, seed, cyc, pdCount, i, k, n;

    fast_lockup_control fast_lockup_control_i (.ref_clk, .reset, .serialClk, .serialData, .loadEnable,
        .power_down_release, .pdClk, .numerator_q, .integer_q, .normal_pump_current_code_q,
        .boost_pump_current_code_q, .boost_enable_q, .boostActive_q, .filterSwitch_q, .pumpUnits_q);
    serial_host serial_host_i (.ref_clk, .reset, .start, .frame, .serialClk, .serialData, .loadEnable, .busy);

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic fail(input logic [19:0] got, input logic [19:0] exp);
        n_mismatch++;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
    endtask

    task automatic chk(input logic [19:0] got, input logic [19:0] exp);
        samples_checked++;
        if (got !== exp) fail(got, exp);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic send(input logic [3:0] a, input logic [19:0] d);
        @(posedge ref_clk);
        frame <= {d, a};
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        // busy only shows one edge after the host took the request
        @(posedge ref_clk);
        for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge ref_clk);
        if (busy !== 1'b0) fail(20'h1, 20'h0);
        // pins pass a synchroniser, so the commit lands a few cycles after the latch
        repeat (8) @(posedge ref_clk);
    endtask

    // phase-detector edges run only while waiting for the boost to expire
    task automatic run_pd;
        pdCount = 0;
        pdRun <= 1'b1;
        for (i = 0; i < 400 && boostActive_q !== 1'b0; i++) @(posedge ref_clk);
        pdRun <= 1'b0;
        if (boostActive_q !== 1'b0) fail(20'h1, 20'h0);
    endtask

    // phase-detector clock runs only when asked, so every rise can be counted
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        pdClk <= pdRun & cyc[2];
        if (pdRun && cyc[2:0] == 3'h4 && boostActive_q === 1'b1) pdCount <= pdCount + 1;
        if (cyc == 8000) begin
            n_mismatch++;
            summarize;
        end
    end

    always @(posedge ref_clk) begin
        unitsPrev <= pumpUnits_q;
        if (!reset && pumpUnits_q !== unitsPrev) begin
            samples_checked++;
            if (expQ.size() == 0) fail(20'(pumpUnits_q), 20'h0);
            else if ({pumpUnits_q, boostActive_q} !== expQ.pop_front()) fail(20'(pumpUnits_q), 20'h1);
            if (filterSwitch_q !== boostActive_q) fail(20'(filterSwitch_q), 20'(boostActive_q));
        end
    end

    initial begin
        seed = 6;
        n_mismatch = 0;
        samples_checked = 0;
        cyc = 0;
        pdCount = 0;
        prevNum = 18'h00000;
        reset = 1'b1;
        start = 1'b0;
        frame = 24'h000000;
        power_down_release = 1'b1;
        pdRun = 1'b0;
        pdClk = 1'b0;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (6) @(posedge ref_clk);
        chk(20'({pumpUnits_q, boostActive_q, filterSwitch_q}), 20'h04);
        $display("reset test done");
        for (k = 0; k < 3; k++) begin
            boostCode = 3'($random(seed));
            normCode = 4'hB + 4'($unsigned($random(seed)) % 5);
            n = (k == 0) ? 1 : 2 + ($unsigned($random(seed)) % 20);
            num = 18'($random(seed));
            intv = 15'($random(seed));
            send(`ADDR_NUM, 20'(num));
            chk(20'(numerator_q), 20'(prevNum));
            send(`ADDR_FAST, {3'h0, 1'b1, boostCode, 13'(n)});
            chk(20'({boost_enable_q, boost_pump_current_code_q}), 20'({1'b1, boostCode}));
            expQ.push_back({5'(boostCode) + 5'h04, 1'b1});
            expQ.push_back({5'(normCode) + 5'h01, 1'b0});
            send(`ADDR_INT, {1'b0, normCode, intv});
            chk(20'({numerator_q, boostActive_q}), 20'({num, 1'b1}));
            chk(20'({normal_pump_current_code_q, integer_q}), 20'({normCode, intv}));
            run_pd;
            chk(20'(pdCount), 20'(n));
            prevNum = num;
            $display("boost test %0d done", k);
        end
        // a fast write during boost does not reload; the next integer write does, from the newest count
        send(`ADDR_FAST, {3'h0, 1'b1, 3'h2, 13'h0002});
        expQ.push_back({5'h06, 1'b1});
        expQ.push_back({5'(normCode) + 5'h01, 1'b0});
        send(`ADDR_INT, {1'b0, normCode, intv});
        send(`ADDR_FAST, {3'h0, 1'b1, 3'h2, 13'h0005});
        chk(20'(boostActive_q), 20'h1);
        send(`ADDR_INT, {1'b0, normCode, intv});
        run_pd;
        chk(20'(pdCount), 20'h5);
        $display("restart test done");
        send(`ADDR_FAST, {3'h0, 1'b0, 3'h7, 13'h0005});
        send(4'h3, 20'hFFFFF);
        chk(20'({boost_enable_q, boost_pump_current_code_q}), 20'h7);
        power_down_release <= 1'b0;
        send(`ADDR_INT, 20'h7FFFF);
        chk(20'(integer_q), 20'(intv));
        power_down_release <= 1'b1;
        expQ.push_back({5'h01, 1'b0});
        send(`ADDR_INT, {1'b0, 4'h0, intv});
        chk(20'({boostActive_q, boost_enable_q}), 20'h0);
        chk(20'(expQ.size()), 20'h0);
        $display("disable and refusal test done");
        summarize;
    end
endmodule // fast_lockup_control_bench
